// ==== verilog/usct_pkg.sv ====
// Package: register map, field positions, reset values and state codes
package usct_pkg;
	// Register byte offsets
	localparam logic [4:0] OFS_CSA  = 5'h00;
	localparam logic [4:0] OFS_CSB  = 5'h04;
	localparam logic [4:0] OFS_CSC  = 5'h08;
	localparam logic [4:0] OFS_DATA = 5'h0C;
	localparam logic [4:0] OFS_BAUD = 5'h10;
	// Control/status A field positions
	localparam int CSA_RXC = 7;
	localparam int CSA_TXC = 6;
	localparam int CSA_TXE = 5;
	localparam int CSA_FE  = 4;
	localparam int CSA_U2X = 1;
	// Control/status B field positions
	localparam int CSB_RXEN = 4;
	localparam int CSB_TX_ENABLE_BIT = 3;
	localparam int CSB_CS2  = 2;
	localparam int CSB_RX8  = 1;
	localparam int CSB_TX8  = 0;
	// Control/status C field positions
	localparam int CSC_MSTR = 7;
	localparam int CSC_SYNC = 6;
	localparam int CSC_PM   = 4;
	localparam int CSC_SBS  = 3;
	localparam int CSC_CS   = 1;
	localparam int CSC_POL  = 0;
	// Reset values
	localparam logic [2:0]  RST_CS   = 3'h3;
	localparam logic [11:0] RST_BAUD = 12'h000;
	// Samples per bit minus one, and half-bit points
	localparam logic [3:0] OVS_NORM  = 4'hF;
	localparam logic [3:0] OVS_DBL   = 4'h7;
	localparam logic [3:0] HALF_NORM = 4'h7;
	localparam logic [3:0] HALF_DBL  = 4'h3;
	// Character size coding
	localparam logic [3:0] DATA_MIN  = 4'h5;
	localparam logic [3:0] NINE_BITS = 4'h9;
	localparam logic [2:0] CS_NINE   = 3'h7;
	localparam logic [8:0] DATA_ALL  = 9'h1FF;
	// Bus responses
	localparam logic [1:0] RESP_OK     = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Frame state codes
	typedef enum logic [2:0] {TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
		TX_PAR = 3'b011, TX_STOP = 3'b100} usct_tx_type;
	typedef enum logic [2:0] {RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
		RX_PAR = 3'b011, RX_STOP = 3'b100} usct_rx_type;
endpackage

// ==== verilog/usct_sync_edge.sv ====
// Synchroniser and edge detector for the external transfer clock
`timescale 1ns/10ps
`default_nettype none
module usct_sync_edge (
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Pin side
	input  wire logic pin_in,
	// Edge pulses
	output logic      rise,
	output logic      fall
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} usct_sync_type;

	usct_sync_type s_q;
	usct_sync_type s_d;

	// Two-stage sync then edge compare, two clocks of delay
	always_comb begin
		s_d      = s_q;
		s_d.meta = pin_in;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Edges seen only after the second stage
	assign rise = s_q.sync & ~s_q.prev;
	assign fall = ~s_q.sync & s_q.prev;
endmodule // usct_sync_edge
`default_nettype wire

// ==== verilog/usct_baud_gen.sv ====
// Baud rate down-counter producing one tick per reload
`timescale 1ns/10ps
`default_nettype none
module usct_baud_gen #(
	parameter int W = 12
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// Divisor and reload strobe
	input  wire logic [W-1:0] divisor,
	input  wire logic         load,
	// Tick out
	output logic              tick
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} usct_baud_type;

	usct_baud_type s_q;
	usct_baud_type s_d;

	// Reload at zero or on divisor write, else count down
	always_comb begin
		s_d = s_q;
		if (load || s_q.cnt == '0) begin
			s_d.cnt = divisor;
		end else begin
			s_d.cnt = s_q.cnt - W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = (s_q.cnt == '0);
endmodule // usct_baud_gen
`default_nettype wire

// ==== verilog/usct_top.sv ====
// Serial transceiver top: register slave, clocking, transmitter and receiver
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Double speed: bit is eight ticks
// - Double speed receiver uses eight samples
// - Slave clock synchronised then edge detected
// - Master drives clock pin, slave reads it
// - Sample edge opposite to change edge
// - Polarity picks change and sample edges
// - Five to nine bits, parity, stops
// - Start, data LSB first, parity, stops
// - Back-to-back frames or idle high line
// - Start bit low, stop bits high
// - One shared frame format for both directions
// - Framing error only from first stop
// - Parity is data XOR, inverted when odd
// - Transmit enable takes over output pin
// - Data register write loads transmit buffer
// - Buffer moves to shifter when idle
// - Unused high data bits ignored
// - Baud down-counter reloads at zero or write
// - Empty flag tracks transmit buffer
// - Complete flag set at end, write-one clears
// - Size code seven means nine bits
module usct_top #(
	parameter int BAUD_W = 12
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// AXI4-Lite write channels
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Serial lines
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin,
	output logic             serial_out_en,
	// Transfer clock pin
	input  wire logic        xfer_clock_pin_in,
	output logic             xfer_clock_pin_out,
	output logic             xfer_clock_pin_oe_n
);
	typedef struct packed {
		logic                  awr;
		logic                  wr;
		logic                  bv;
		logic [1:0]            br;
		logic                  arr;
		logic                  rv;
		logic [1:0]            rr;
		logic [31:0]           rd;
		logic                  u2x;
		logic                  rxen;
		logic                  tx_enable_bit;
		logic                  tx8;
		logic                  mstr;
		logic                  sync;
		logic [1:0]            pm;
		logic                  sbs;
		logic [2:0]            cs;
		logic                  pol;
		logic [BAUD_W-1:0]     baud;
		logic                  bld;
		logic                  txc;
		logic                  fe;
		logic                  rx_complete_flag;
		logic [8:0]            rxd;
		logic [8:0]            tbuf;
		logic                  bfull;
		usct_pkg::usct_tx_type tst;
		logic [8:0]            tsh;
		logic [3:0]            tidx;
		logic                  tsc;
		logic                  ser;
		logic                  soe;
		logic [3:0]            pre;
		logic                  xck;
		logic                  xoe_n;
		usct_pkg::usct_rx_type rxs;
		logic [8:0]            rsh;
		logic [3:0]            ridx;
		logic [3:0]            rc;
	} usct_state_type;

	usct_state_type s_q;
	usct_state_type s_d;

	logic       tick;
	logic       xrise;
	logic       xfall;
	logic [3:0] nbits;
	logic [8:0] msk;
	logic [3:0] lim;
	logic [3:0] half;
	logic       par_en;
	logic       mclk;
	logic       chg;
	logic       smp;
	logic       rbit;
	logic       load;
	logic       wr_go;
	logic       rd_go;

	// Baud rate generator
	usct_baud_gen #(
		.W       (BAUD_W)
	) u_baud (
		.clk     (clk),
		.sys_rst (sys_rst),
		.divisor (s_q.baud),
		.load    (s_q.bld),
		.tick    (tick)
	);

	// External clock synchroniser for slave mode
	usct_sync_edge u_xsync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin_in  (xfer_clock_pin_in),
		.rise    (xrise),
		.fall    (xfall)
	);

	// Shared frame format decode for both directions
	assign nbits  = (s_q.cs == usct_pkg::CS_NINE) ? usct_pkg::NINE_BITS :
		usct_pkg::DATA_MIN + {2'b00, s_q.cs[1:0]};
	assign msk    = usct_pkg::DATA_ALL >> (usct_pkg::NINE_BITS - nbits);
	assign par_en = s_q.pm[1];
	assign lim    = s_q.u2x ? usct_pkg::OVS_DBL : usct_pkg::OVS_NORM;
	assign half   = s_q.u2x ? usct_pkg::HALF_DBL : usct_pkg::HALF_NORM;
	assign mclk   = s_q.sync & s_q.mstr;

	// Change and sample strobes per clock mode and polarity
	always_comb begin
		if (!s_q.sync) begin
			chg = tick && (s_q.pre == lim);
			smp = 1'b0;
		end else if (s_q.mstr) begin
			chg = tick && (~s_q.xck == ~s_q.pol);
			smp = tick && (~s_q.xck == s_q.pol);
		end else begin
			chg = s_q.pol ? xfall : xrise;
			smp = s_q.pol ? xrise : xfall;
		end
	end

	assign rbit  = s_q.sync ? smp : (tick && s_q.rc == lim);
	assign load  = s_q.bfull & s_q.soe;
	assign wr_go = s_q.awr & s_axi_awvalid & s_axi_wvalid;
	assign rd_go = s_q.arr & s_axi_arvalid;

	// Next-state logic for bus, clocking and both frame engines
	always_comb begin
		logic [7:0] rb;
		rb      = 8'h00;
		s_d     = s_q;
		s_d.bld = 1'b0;
		s_d.awr = 1'b0;
		s_d.wr  = 1'b0;
		s_d.arr = 1'b0;
		// Write address and data taken together
		if (s_axi_awvalid && s_axi_wvalid && !s_q.awr && !s_q.bv) begin
			s_d.awr = 1'b1;
			s_d.wr  = 1'b1;
		end
		if (s_q.bv && s_axi_bready) begin
			s_d.bv = 1'b0;
		end
		if (wr_go) begin
			s_d.bv = 1'b1;
			s_d.br = usct_pkg::RESP_OK;
			case (s_axi_awaddr)
				usct_pkg::OFS_CSA: if (s_axi_wstrb[0]) begin
					s_d.u2x = s_axi_wdata[usct_pkg::CSA_U2X];
					if (s_axi_wdata[usct_pkg::CSA_TXC]) s_d.txc = 1'b0;
				end
				usct_pkg::OFS_CSB: if (s_axi_wstrb[0]) begin
					s_d.rxen  = s_axi_wdata[usct_pkg::CSB_RXEN];
					s_d.tx_enable_bit  = s_axi_wdata[usct_pkg::CSB_TX_ENABLE_BIT];
					s_d.cs[2] = s_axi_wdata[usct_pkg::CSB_CS2];
					s_d.tx8   = s_axi_wdata[usct_pkg::CSB_TX8];
				end
				usct_pkg::OFS_CSC: if (s_axi_wstrb[0]) begin
					s_d.mstr    = s_axi_wdata[usct_pkg::CSC_MSTR];
					s_d.sync    = s_axi_wdata[usct_pkg::CSC_SYNC];
					s_d.pm      = s_axi_wdata[usct_pkg::CSC_PM +: 2];
					s_d.sbs     = s_axi_wdata[usct_pkg::CSC_SBS];
					s_d.cs[1:0] = s_axi_wdata[usct_pkg::CSC_CS +: 2];
					s_d.pol     = s_axi_wdata[usct_pkg::CSC_POL];
				end
				usct_pkg::OFS_DATA: if (s_axi_wstrb[0] && !s_q.bfull) begin
					s_d.tbuf  = {s_q.tx8, s_axi_wdata[7:0]};
					s_d.bfull = 1'b1;
				end
				usct_pkg::OFS_BAUD: begin
					if (s_axi_wstrb[0]) begin
						s_d.baud[7:0] = s_axi_wdata[7:0];
						s_d.bld       = 1'b1;
					end
					if (s_axi_wstrb[1]) s_d.baud[BAUD_W-1:8] = s_axi_wdata[BAUD_W-1:8];
				end
				default: s_d.br = usct_pkg::RESP_SLVERR;
			endcase
		end
		// Read address taken, data answered next cycle
		if (s_axi_arvalid && !s_q.arr && !s_q.rv) begin
			s_d.arr = 1'b1;
		end
		if (s_q.rv && s_axi_rready) begin
			s_d.rv = 1'b0;
		end
		if (rd_go) begin
			s_d.rv = 1'b1;
			s_d.rr = usct_pkg::RESP_OK;
			case (s_axi_araddr)
				usct_pkg::OFS_CSA: begin
					rb[usct_pkg::CSA_RXC] = s_q.rx_complete_flag;
					rb[usct_pkg::CSA_TXC] = s_q.txc;
					rb[usct_pkg::CSA_TXE] = ~s_q.bfull;
					rb[usct_pkg::CSA_FE]  = s_q.fe;
					rb[usct_pkg::CSA_U2X] = s_q.u2x;
				end
				usct_pkg::OFS_CSB: begin
					rb[usct_pkg::CSB_RXEN] = s_q.rxen;
					rb[usct_pkg::CSB_TX_ENABLE_BIT] = s_q.tx_enable_bit;
					rb[usct_pkg::CSB_CS2]  = s_q.cs[2];
					rb[usct_pkg::CSB_RX8]  = s_q.rxd[8];
					rb[usct_pkg::CSB_TX8]  = s_q.tx8;
				end
				usct_pkg::OFS_CSC: begin
					rb[usct_pkg::CSC_MSTR]      = s_q.mstr;
					rb[usct_pkg::CSC_SYNC]      = s_q.sync;
					rb[usct_pkg::CSC_PM +: 2]   = s_q.pm;
					rb[usct_pkg::CSC_SBS]       = s_q.sbs;
					rb[usct_pkg::CSC_CS +: 2]   = s_q.cs[1:0];
					rb[usct_pkg::CSC_POL]       = s_q.pol;
				end
				usct_pkg::OFS_DATA: begin
					rb      = s_q.rxd[7:0];
					s_d.rx_complete_flag = 1'b0;
				end
				default: s_d.rr = usct_pkg::RESP_SLVERR;
			endcase
			s_d.rd = {24'h000000, rb};
			if (s_axi_araddr == usct_pkg::OFS_BAUD) begin
				s_d.rd = 32'(s_q.baud);
				s_d.rr = usct_pkg::RESP_OK;
			end
		end
		// Oversampling prescaler and master clock output
		if (!s_q.sync && tick) begin
			s_d.pre = (s_q.pre == lim) ? 4'h0 : s_q.pre + 4'h1;
		end
		if (mclk) begin
			if (tick) s_d.xck = ~s_q.xck;
		end else begin
			s_d.xck = s_q.pol;
		end
		s_d.xoe_n = ~mclk;
		// Pin ownership lasts until pending frames drain
		s_d.soe = s_q.tx_enable_bit | (s_q.soe & (s_q.bfull | (s_q.tst != usct_pkg::TX_IDLE)));
		// Transmit frame engine
		case (s_q.tst)
			usct_pkg::TX_IDLE: begin
				s_d.ser = 1'b1;
				if (chg && load) begin
					s_d.tsh   = s_q.tbuf & msk;
					s_d.bfull = 1'b0;
					s_d.tst   = usct_pkg::TX_START;
					s_d.ser   = 1'b0;
				end
			end
			usct_pkg::TX_START: if (chg) begin
				s_d.tst  = usct_pkg::TX_DATA;
				s_d.tidx = 4'h0;
				s_d.ser  = s_q.tsh[0];
			end
			usct_pkg::TX_DATA: if (chg) begin
				if (s_q.tidx == nbits - 4'h1) begin
					if (par_en) begin
						s_d.tst = usct_pkg::TX_PAR;
						s_d.ser = ^s_q.tsh ^ s_q.pm[0];
					end else begin
						s_d.tst = usct_pkg::TX_STOP;
						s_d.ser = 1'b1;
						s_d.tsc = 1'b0;
					end
				end else begin
					s_d.tidx = s_q.tidx + 4'h1;
					s_d.ser  = s_q.tsh[s_q.tidx + 4'h1];
				end
			end
			usct_pkg::TX_PAR: if (chg) begin
				s_d.tst = usct_pkg::TX_STOP;
				s_d.ser = 1'b1;
				s_d.tsc = 1'b0;
			end
			usct_pkg::TX_STOP: if (chg) begin
				if (s_q.sbs && !s_q.tsc) begin
					s_d.tsc = 1'b1;
				end else if (load) begin
					s_d.tsh   = s_q.tbuf & msk;
					s_d.bfull = 1'b0;
					s_d.tst   = usct_pkg::TX_START;
					s_d.ser   = 1'b0;
				end else begin
					s_d.tst = usct_pkg::TX_IDLE;
					s_d.txc = 1'b1;
				end
			end
			default: s_d.tst = usct_pkg::TX_IDLE;
		endcase
		// Receive bit timing within a frame
		if (!s_q.sync && tick && s_q.rxs != usct_pkg::RX_IDLE && s_q.rxs != usct_pkg::RX_START) begin
			s_d.rc = (s_q.rc == lim) ? 4'h0 : s_q.rc + 4'h1;
		end
		// Receive frame engine
		case (s_q.rxs)
			usct_pkg::RX_IDLE: begin
				if (s_q.rxen && (s_q.sync ? smp : tick) && !serial_in_pin) begin
					s_d.rsh  = 9'h000;
					s_d.ridx = 4'h0;
					s_d.rc   = 4'h0;
					s_d.rxs  = s_q.sync ? usct_pkg::RX_DATA : usct_pkg::RX_START;
				end
			end
			usct_pkg::RX_START: if (tick) begin
				s_d.rc = s_q.rc + 4'h1;
				if (s_q.rc == half) begin
					s_d.rc  = 4'h0;
					s_d.rxs = serial_in_pin ? usct_pkg::RX_IDLE : usct_pkg::RX_DATA;
				end
			end
			usct_pkg::RX_DATA: if (rbit) begin
				s_d.rsh[s_q.ridx] = serial_in_pin;
				s_d.ridx          = s_q.ridx + 4'h1;
				if (s_q.ridx == nbits - 4'h1) begin
					s_d.rxs = par_en ? usct_pkg::RX_PAR : usct_pkg::RX_STOP;
				end
			end
			usct_pkg::RX_PAR: if (rbit) begin
				s_d.rxs = usct_pkg::RX_STOP;
			end
			usct_pkg::RX_STOP: if (rbit) begin
				s_d.fe  = ~serial_in_pin;
				s_d.rxd = s_q.rsh;
				s_d.rx_complete_flag = 1'b1;
				s_d.rxs = usct_pkg::RX_IDLE;
			end
			default: s_d.rxs = usct_pkg::RX_IDLE;
		endcase
	end

	// State register with synchronous reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q       <= '0;
			s_q.cs    <= usct_pkg::RST_CS;
			s_q.baud  <= BAUD_W'(usct_pkg::RST_BAUD);
			s_q.ser   <= 1'b1;
			s_q.xoe_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign s_axi_awready       = s_q.awr;
	assign s_axi_wready        = s_q.wr;
	assign s_axi_bvalid        = s_q.bv;
	assign s_axi_bresp         = s_q.br;
	assign s_axi_arready       = s_q.arr;
	assign s_axi_rvalid        = s_q.rv;
	assign s_axi_rresp         = s_q.rr;
	assign s_axi_rdata         = s_q.rd;
	assign serial_out_pin      = s_q.ser;
	assign serial_out_en       = s_q.soe;
	assign xfer_clock_pin_out  = s_q.xck;
	assign xfer_clock_pin_oe_n = s_q.xoe_n;

	// Checks on frame shape, clocking and flags
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	start_low_a: assert property (s_q.tst == usct_pkg::TX_START |-> !serial_out_pin)
		else $error("start bit not low");
	stop_high_a: assert property (s_q.tst == usct_pkg::TX_STOP |-> serial_out_pin)
		else $error("stop bit not high");
	idle_high_a: assert property (s_q.tst == usct_pkg::TX_IDLE |-> serial_out_pin)
		else $error("idle line not high");
	parity_bit_a: assert property (s_q.tst == usct_pkg::TX_PAR |->
		serial_out_pin == (^s_q.tsh ^ s_q.pm[0])) else $error("parity bit wrong");
	data_count_a: assert property (s_q.tst == usct_pkg::TX_DATA |-> s_q.tidx < nbits)
		else $error("data index past size");
	buffer_load_a: assert property (wr_go && s_axi_awaddr == usct_pkg::OFS_DATA
		&& s_axi_wstrb[0] |=> s_q.bfull) else $error("data write not buffered");
	tx_done_a: assert property ($rose(s_q.txc) |->
		$past(s_q.tst) == usct_pkg::TX_STOP && !$past(load)) else $error("complete flag bad");
	frame_err_a: assert property ($rose(s_q.fe) |->
		$past(s_q.rxs) == usct_pkg::RX_STOP && !$past(serial_in_pin)) else $error("bad fe");
	async_step_a: assert property (!s_q.sync && chg |-> s_q.pre == lim ##1 !chg)
		else $error("async bit step wrong");
	master_clk_a: assert property (mclk |=> !xfer_clock_pin_oe_n)
		else $error("master not driving clock");
	slave_edge_a: assert property (s_q.sync && !s_q.mstr && chg |->
		$past(xfer_clock_pin_in, 2) != $past(xfer_clock_pin_in, 3) &&
		$past(xfer_clock_pin_in, 2) == !s_q.pol)
		else $error("slave edge timing wrong");
endmodule // usct_top
`default_nettype wire

// ==== dv/usct_peer.sv ====
// Serial peer model: decodes transmit frames and sends receive frames
`timescale 1ns/10ps
`default_nettype none
module usct_peer (
	// Clock
	input  wire logic        clk,
	// Line format
	input  wire logic [15:0] bit_clks,
	input  wire logic [3:0]  nbits,
	input  wire logic        par_en,
	input  wire logic        two_stop,
	// Serial lines
	input  wire logic        line_in,
	output logic             line_out
);
	logic [10:0] q[$];
	logic [10:0] w;
	initial line_out = 1'b1;
	// Decoder: stop flag, parity, data bits
	always begin
		@(posedge clk);
		if (line_in === 1'b0) begin
			w = 11'h400;
			repeat (bit_clks / 2) @(posedge clk);
			for (int i = 0; i < nbits; i++) begin
				repeat (bit_clks) @(posedge clk);
				w[i] = line_in;
			end
			if (par_en) begin
				repeat (bit_clks) @(posedge clk);
				w[9] = line_in;
			end
			for (int i = 0; i <= two_stop; i++) begin
				repeat (bit_clks) @(posedge clk);
				w[10] = w[10] & line_in;
			end
			q.push_back(w);
		end
	end
	// Sends start, data LSB first, first and second stop
	task automatic send(input logic [7:0] d, input logic s1, input logic s2);
		line_out <= 1'b0;
		repeat (bit_clks) @(posedge clk);
		for (int i = 0; i < nbits; i++) begin
			line_out <= d[i];
			repeat (bit_clks) @(posedge clk);
		end
		line_out <= s1;
		repeat (bit_clks) @(posedge clk);
		line_out <= s2;
		if (two_stop) repeat (bit_clks) @(posedge clk);
		line_out <= 1'b1;
	endtask
endmodule // usct_peer
`default_nettype wire

// ==== dv/usct_top_test.sv ====
// Testbench for the serial transceiver top
`timescale 1ns/10ps
`default_nettype none
module usct_top_test;
	logic        clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rd_d, cyc, t1, t2, dat;
	logic [1:0]  rd_r, wr_r, pm;
	logic [2:0]  xdiv;
	logic        xin;
	logic [15:0] bit_clks;
	logic [3:0]  nbits;
	logic [2:0]  c;
	logic        par_en, two_stop, sync_chk, pol, prev, sb, u2, rx_line, tx_line;
	wire         awready, wready, bvalid, arready, rvalid, so_pin, so_en, xck, xck_oe_n;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	int          err_count, n_tests;
	logic [2:0]  cs_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	logic [1:0]  pm_tab [3] = '{2'h0, 2'h2, 2'h3};
	// Released line is pulled high
	assign tx_line = so_en ? so_pin : 1'b1;
	usct_top i_usct_top (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .serial_in_pin(rx_line), .serial_out_pin(so_pin),
		.serial_out_en(so_en), .xfer_clock_pin_in(xin), .xfer_clock_pin_out(xck),
		.xfer_clock_pin_oe_n(xck_oe_n));
	usct_peer i_usct_peer (.clk(clk), .bit_clks(bit_clks), .nbits(nbits), .par_en(par_en),
		.two_stop(two_stop), .line_in(tx_line), .line_out(rx_line));
	// Clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Cycle counter and hang limit
	always @(posedge clk) begin
		cyc <= cyc + 32'h1;
		if (cyc == 32'd40000) begin
			err_count++;
			$display("Error at %0t: timeout", $time);
			final_report();
		end
	end
	// Free-running slave clock, period 12 system clocks
	always @(posedge clk) begin
		xdiv <= (xdiv == 3'h5) ? 3'h0 : xdiv + 3'h1;
		if (xdiv == 3'h5) xin <= ~xin;
	end
	// Sync mode: data changes only with the change edge
	always @(posedge clk) begin
		if (sync_chk && so_en && so_pin !== prev) chk({31'h0, (xck_oe_n ? xin : xck)}, {31'h0, ~pol});
		prev <= so_pin;
	end
	task automatic final_report();
		$display("Counts: %0d errors, %0d checks", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Bus write, address and data released as taken
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge clk);
			if (awready === 1'b1) begin awvalid <= 1'b0; ta = 1'b1; end
			if (wready === 1'b1) begin wvalid <= 1'b0; tw = 1'b1; end
		end
		bready <= 1'b1;
		do @(posedge clk); while (bvalid !== 1'b1);
		wr_r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk); while (rvalid !== 1'b1);
		rd_d = rdata;
		rd_r = rresp;
		rready <= 1'b0;
	endtask
	// Reads until a masked bit is set
	task automatic poll(input logic [4:0] a, input logic [31:0] m);
		do rd(a); while ((rd_d & m) == 32'h0);
	endtask
	// Expected decode: stop flag, parity, masked data
	function automatic logic [31:0] expf(input logic [31:0] d, input int n, input logic [1:0] p);
		logic [8:0] m;
		m = d[8:0] & ~(9'h1FF << n);
		return {21'h0, 1'b1, p[1] & (^m ^ p[0]), m};
	endfunction
	// Main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, sync_chk, pol, prev} = 8'h00;
		{awaddr, araddr, wdata, cyc, err_count, n_tests} = '0;
		{xin, xdiv} = 4'h0;
		{bit_clks, nbits, par_en, two_stop} = {16'd16, 4'd8, 2'b00};
		sys_rst = 1'b1;
		void'($urandom(32'h02a8e174));
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rd(usct_pkg::OFS_CSA); chk(rd_d, 32'h20);
		rd(usct_pkg::OFS_CSC); chk(rd_d, 32'h06);
		rd(usct_pkg::OFS_BAUD); chk(rd_d, 32'h0);
		rd(5'h14); chk({30'h0, rd_r}, {30'h0, usct_pkg::RESP_SLVERR});
		wr(5'h14, 32'h0); chk({30'h0, wr_r}, {30'h0, usct_pkg::RESP_SLVERR});
		chk({31'h0, so_en}, 32'h0);
		// Size codes 0-3 and 7 against parity codes 0, 2 and 3
		for (int i = 0; i < 15; i++) begin
			c = cs_tab[i % 5];
			pm = pm_tab[i / 5];
			sb = $urandom;
			u2 = $urandom;
			dat = $urandom;
			nbits = (c == 3'h7) ? 4'd9 : 4'd5 + c;
			{par_en, two_stop, bit_clks} = {pm[1], sb, u2 ? 16'd8 : 16'd16};
			wr(usct_pkg::OFS_CSA, {25'h0, 1'b1, 4'h0, u2, 1'b0});
			wr(usct_pkg::OFS_CSB, {28'h1, c[2], 1'b0, dat[8]});
			wr(usct_pkg::OFS_CSC, {26'h0, pm, sb, c[1:0], 1'b0});
			chk({31'h0, so_en}, 32'h1);
			wr(usct_pkg::OFS_DATA, dat);
			while (i_usct_peer.q.size() == 0) @(posedge clk);
			chk({21'h0, i_usct_peer.q.pop_front()}, expf(dat, nbits, pm));
			poll(usct_pkg::OFS_CSA, 32'h40);
			chk(rd_d, {24'h0, 3'h3, 3'h0, u2, 1'b0});
		end
		wr(usct_pkg::OFS_CSA, 32'h40);
		rd(usct_pkg::OFS_CSA); chk(rd_d, 32'h20);
		// Two frames back to back at 8N1
		{par_en, two_stop, bit_clks, nbits} = {2'b00, 16'd16, 4'd8};
		wr(usct_pkg::OFS_CSB, 32'h08);
		chk({30'h0, wr_r}, {30'h0, usct_pkg::RESP_OK});
		wr(usct_pkg::OFS_CSC, 32'h06);
		dat = $urandom;
		wr(usct_pkg::OFS_DATA, {24'h0, dat[7:0]});
		poll(usct_pkg::OFS_CSA, 32'h20);
		wr(usct_pkg::OFS_DATA, {24'h0, dat[15:8]});
		rd(usct_pkg::OFS_CSA); chk(rd_d & 32'h20, 32'h0);
		while (i_usct_peer.q.size() < 1) @(posedge clk);
		t1 = cyc;
		while (i_usct_peer.q.size() < 2) @(posedge clk);
		t2 = cyc;
		chk(t2 - t1, 32'd160);
		chk({21'h0, i_usct_peer.q.pop_front()}, {24'h4, dat[7:0]});
		chk({21'h0, i_usct_peer.q.pop_front()}, {24'h4, dat[15:8]});
		// Receive: good frame, bad first stop, two good stops
		wr(usct_pkg::OFS_CSB, 32'h18);
		for (int i = 0; i < 3; i++) begin
			dat = $urandom;
			two_stop = (i != 0);
			wr(usct_pkg::OFS_CSC, {28'h0, two_stop, 3'h6});
			i_usct_peer.send(dat[7:0], i != 1, 1'b1);
			poll(usct_pkg::OFS_CSA, 32'h80);
			chk(rd_d & 32'h10, (i == 1) ? 32'h10 : 32'h0);
			rd(usct_pkg::OFS_DATA); chk(rd_d, {24'h0, dat[7:0]});
		end
		// Master then slave synchronous mode, both polarities
		wr(usct_pkg::OFS_CSA, 32'h40);
		for (int p = 0; p < 4; p++) begin
			pol = p[0];
			wr(usct_pkg::OFS_CSC, {24'h0, !p[1], 6'h23, pol});
			@(posedge clk);
			chk({31'h0, xck_oe_n}, {31'h0, p[1]});
			sync_chk = 1'b1;
			wr(usct_pkg::OFS_CSA, 32'h40);
			wr(usct_pkg::OFS_DATA, $urandom);
			poll(usct_pkg::OFS_CSA, 32'h40);
			sync_chk = 1'b0;
		end
		wr(usct_pkg::OFS_CSC, 32'h06);
		@(posedge clk);
		chk({31'h0, xck_oe_n}, 32'h1);
		final_report();
	end
endmodule // usct_top_test
`default_nettype wire
